//--- design/msc_pkg.sv
package msc_pkg;

  // Register offsets on the software port
  localparam logic [7:0] MSC_OFS_MODE_CONTROL   = 8'h00;
  localparam logic [7:0] MSC_OFS_SYSTEM_CONTROL = 8'h01;

  // Mode control field positions
  localparam int MSC_MC_EXTENDED_MODE_ENABLE_BIT = 7;
  localparam int MSC_MC_RSV_HI   = 6;
  localparam int MSC_MC_RSV_LO   = 3;
  localparam int MSC_MC_PIN2_BIT = 2;

  // System control field positions
  localparam int MSC_SC_RSV7_BIT  = 7;
  localparam int MSC_SC_STROBE_FUNCTION_SELECT_BIT  = 6;
  localparam int MSC_SC_IRQ_CTRL_MODE_HI_BIT = 5;
  localparam int MSC_SC_IRQ_CTRL_MODE_LO_BIT = 4;
  localparam int MSC_SC_RESET_SOURCE_FLAG_BIT  = 3;
  localparam int MSC_SC_NONMASKABLE_EDGE_SELECT_BIT = 2;
  localparam int MSC_SC_RSV1_BIT  = 1;
  localparam int MSC_SC_ONCHIP_RAM_ENABLE_BIT  = 0;

  // Reset values
  localparam logic MSC_RST_EXTENDED_MODE_ENABLE  = 1'b0;
  localparam logic MSC_RST_STROBE_FUNCTION_SELECT  = 1'b0;
  localparam logic MSC_RST_IRQ_CTRL_MODE_LO = 1'b0;
  localparam logic MSC_RST_NONMASKABLE_EDGE_SELECT = 1'b0;
  localparam logic MSC_RST_RSV1  = 1'b0;
  localparam logic MSC_RST_ONCHIP_RAM_ENABLE  = 1'b1;

  // Mode pin codes
  localparam logic [2:0] MSC_PINS_MODE1 = 3'h1;
  localparam logic [2:0] MSC_PINS_MODE2 = 3'h2;
  localparam logic [2:0] MSC_PINS_MODE3 = 3'h3;

  // I/O strobe address window, low 16 bits of the address
  localparam logic [15:0] MSC_IOS_LO = 16'hf000;
  localparam logic [15:0] MSC_IOS_HI = 16'hf7ff;

  // Decoded operating mode
  typedef enum logic [1:0] {
    MSC_MODE_OTHER,
    MSC_MODE_1,
    MSC_MODE_2,
    MSC_MODE_3
  } msc_opmode_t;

endpackage

//--- design/msc_regs.sv
`timescale 1ns/1ps
module msc_regs
  import msc_pkg::*;
#(
  parameter int  BUS_ADDR_W = 24,
  parameter bit  HAS_PIN2   = 1'b1
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  wdt_overflow,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  mode_select_pin_2,
  input  wire logic                  mode_select_pin_1,
  input  wire logic                  mode_select_pin_0,
  input  wire logic                  ext_access,
  input  wire logic [BUS_ADDR_W-1:0] ext_addr,
  input  wire logic                  nmi_in,
  output logic                       nmi_request,
  output logic                       shared_strobe_pin_n,
  output logic                       shared_strobe_pin_oe,
  output logic                       extended_mode_enable,
  output logic [1:0]                 irq_ctrl_mode,
  output logic                       onchip_ram_enable,
  output logic                       reset_source_flag,
  output logic [2:0]                 mode_pin_status
);

  // Refuse widths the strobe decode cannot serve
  if (BUS_ADDR_W < 16) begin : g_chk
    $error("msc_regs: BUS_ADDR_W must be at least 16");
  end

  // Register map seen by software
  //
  // mode_control, offset MSC_OFS_MODE_CONTROL
  //   bit 7    extended_mode_enable
  //            mode 1: held at one, writes dropped
  //            modes 2 and 3: zero single-chip, one extended
  //            other pin codes: value kept, writes dropped
  //   bits 6-3 reserved, read zero, writes dropped
  //   bits 2-0 mode pin status, read-only
  //            read value shows the pins in the read cycle
  //            the status latch takes the pins again at every read
  //            and follows the pins again after a reset
  //
  // system_control, offset MSC_OFS_SYSTEM_CONTROL
  //   bit 7    reserved, reads zero
  //   bit 6    strobe_function_select, used in extended mode
  //            zero: address strobe on every external access
  //            one: I/O strobe for the f000-f7ff window only
  //   bit 5    irq_ctrl_mode_hi, reads zero, writes dropped
  //   bit 4    irq_ctrl_mode_lo, software writable
  //   bit 3    reset_source_flag, read-only
  //            one after the reset pin, zero after watchdog
  //   bit 2    nonmaskable_edge_select
  //            zero: falling edge, one: rising edge
  //   bit 1    reserved, stored and read back
  //   bit 0    onchip_ram_enable, one after reset
  //
  // Unmapped offsets: writes dropped, reads return zero
  //
  // Timing
  //   Writes take effect on the edge that samples the strobe.
  //   Read data stand for exactly the cycle after the strobe
  //   and are zero in every other cycle, so the host may
  //   sample them without a separate valid flag.
  //   Strobe and request outputs lag their inputs by one cycle
  //   because every output comes from a flip-flop.
  //   The strobe output enable follows the extended enable
  //   one cycle late, so the pin is released cleanly.
  //
  // Hazards
  //   A watchdog overflow held high keeps the block in reset.
  //   When the reset pin and the watchdog fire together the
  //   pin wins and the reset source reads one.
  //   Mode pins should not move during operation; a change
  //   re-decodes the mode at once.
  //   Interrupt mode codes 10 and 11 cannot be reached, since
  //   the upper mode bit is not stored at all.
  //   The edge detector assumes a high NMI line after reset,
  //   so a line held low through reset raises a falling-edge request in the first cycle after reset.
  //   Software should leave reserved bits at their reset value.

  // Decode the three mode pins into an operating mode
  function automatic msc_opmode_t msc_decode(input logic [2:0] pins);
    msc_opmode_t m;
    m = MSC_MODE_OTHER;
    if (pins == MSC_PINS_MODE1) begin
      m = MSC_MODE_1;
    end else if (pins == MSC_PINS_MODE2) begin
      m = MSC_MODE_2;
    end else if (pins == MSC_PINS_MODE3) begin
      m = MSC_MODE_3;
    end
    return m;
  endfunction

  // Address falls inside the I/O strobe window
  function automatic logic msc_in_ios(input logic [15:0] a);
    return (a >= MSC_IOS_LO) && (a <= MSC_IOS_HI);
  endfunction

  // Pin levels with the missing highest pin forced low
  logic [2:0]  pins_now;
  msc_opmode_t mode_now;
  logic        blk_rst;
  logic        wr_mc;
  logic        wr_sc;
  logic        rd_mc;
  logic        rd_sc;

  assign pins_now = {mode_select_pin_2 & HAS_PIN2,
                     mode_select_pin_1,
                     mode_select_pin_0};
  assign mode_now = msc_decode(pins_now);

  // Watchdog overflow resets the block like the external pin
  assign blk_rst  = rst | wdt_overflow;

  // Address decode of the two registers
  assign wr_mc = reg_wr && (reg_addr == MSC_OFS_MODE_CONTROL);
  assign wr_sc = reg_wr && (reg_addr == MSC_OFS_SYSTEM_CONTROL);
  assign rd_mc = reg_rd && (reg_addr == MSC_OFS_MODE_CONTROL);
  assign rd_sc = reg_rd && (reg_addr == MSC_OFS_SYSTEM_CONTROL);

  // Register state
  logic       extended_mode_enable_reg;
  logic       extended_mode_enable_next;
  logic       strobe_function_select_reg;
  logic       irq_ctrl_mode_lo_reg;
  logic       nonmaskable_edge_select_reg;
  logic       rsv1_reg;
  logic       onchip_ram_enable_reg;
  logic       reset_source_flag_reg;
  logic       latched_reg;
  logic [2:0] status_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       nmi_prev_reg;
  logic       nmi_req_reg;
  logic       nmi_req_next;
  logic       strobe_n_reg;
  logic       strobe_n_next;
  logic       strobe_oe_reg;

  // Extended-mode enable next value
  always_comb begin
    extended_mode_enable_next = extended_mode_enable_reg;
    if (mode_now == MSC_MODE_1) begin
      extended_mode_enable_next = 1'b1;
    end else if (wr_mc && (mode_now == MSC_MODE_2 ||
                           mode_now == MSC_MODE_3)) begin
      extended_mode_enable_next = reg_wdata[MSC_MC_EXTENDED_MODE_ENABLE_BIT];
    end
  end

  // Extended-mode enable bit; mode 1 holds it at one
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      extended_mode_enable_reg <= (mode_now == MSC_MODE_1) ? 1'b1 : MSC_RST_EXTENDED_MODE_ENABLE;
    end else begin
      extended_mode_enable_reg <= extended_mode_enable_next;
    end
  end

  // Status latch flag: set by a read, released by reset
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      latched_reg <= 1'b0;
    end else if (rd_mc) begin
      latched_reg <= 1'b1;
    end
  end

  // Mode pin status: follows pins until a read latches them
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      status_reg <= pins_now;
    end else if (rd_mc || !latched_reg) begin
      status_reg <= pins_now;
    end
  end

  // Strobe function select
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      strobe_function_select_reg <= MSC_RST_STROBE_FUNCTION_SELECT;
    end else if (wr_sc) begin
      strobe_function_select_reg <= reg_wdata[MSC_SC_STROBE_FUNCTION_SELECT_BIT];
    end
  end

  // Lower interrupt control mode bit
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      irq_ctrl_mode_lo_reg <= MSC_RST_IRQ_CTRL_MODE_LO;
    end else if (wr_sc) begin
      irq_ctrl_mode_lo_reg <= reg_wdata[MSC_SC_IRQ_CTRL_MODE_LO_BIT];
    end
  end

  // NMI edge select
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      nonmaskable_edge_select_reg <= MSC_RST_NONMASKABLE_EDGE_SELECT;
    end else if (wr_sc) begin
      nonmaskable_edge_select_reg <= reg_wdata[MSC_SC_NONMASKABLE_EDGE_SELECT_BIT];
    end
  end

  // Reserved bit one, stored and read back
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      rsv1_reg <= MSC_RST_RSV1;
    end else if (wr_sc) begin
      rsv1_reg <= reg_wdata[MSC_SC_RSV1_BIT];
    end
  end

  // On-chip RAM enable
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      onchip_ram_enable_reg <= MSC_RST_ONCHIP_RAM_ENABLE;
    end else if (wr_sc) begin
      onchip_ram_enable_reg <= reg_wdata[MSC_SC_ONCHIP_RAM_ENABLE_BIT];
    end
  end

  // Reset source: set by the reset pin, cleared by watchdog, held in between
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_source_flag_reg <= 1'b1;
    end else if (wdt_overflow) begin
      reset_source_flag_reg <= 1'b0;
    end
  end

  // Read data mux; reserved bits other than system_control bit 1, and unmapped offsets, read zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd_mc) begin
      rdata_next[MSC_MC_EXTENDED_MODE_ENABLE_BIT] = extended_mode_enable_reg;
      rdata_next[MSC_MC_RSV_HI:MSC_MC_RSV_LO] = 4'h0;
      rdata_next[MSC_MC_PIN2_BIT:0] = pins_now;
    end else if (rd_sc) begin
      rdata_next[MSC_SC_RSV7_BIT]  = 1'b0;
      rdata_next[MSC_SC_STROBE_FUNCTION_SELECT_BIT]  = strobe_function_select_reg;
      rdata_next[MSC_SC_IRQ_CTRL_MODE_HI_BIT] = 1'b0;
      rdata_next[MSC_SC_IRQ_CTRL_MODE_LO_BIT] = irq_ctrl_mode_lo_reg;
      rdata_next[MSC_SC_RESET_SOURCE_FLAG_BIT]  = reset_source_flag_reg;
      rdata_next[MSC_SC_NONMASKABLE_EDGE_SELECT_BIT] = nonmaskable_edge_select_reg;
      rdata_next[MSC_SC_RSV1_BIT]  = rsv1_reg;
      rdata_next[MSC_SC_ONCHIP_RAM_ENABLE_BIT]  = onchip_ram_enable_reg;
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // NMI edge request selection
  always_comb begin
    if (nonmaskable_edge_select_reg) begin
      nmi_req_next = nmi_in & ~nmi_prev_reg;
    end else begin
      nmi_req_next = ~nmi_in & nmi_prev_reg;
    end
  end

  // Previous NMI level; idle high after reset
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      nmi_prev_reg <= 1'b1;
    end else begin
      nmi_prev_reg <= nmi_in;
    end
  end

  // One-cycle NMI request pulse
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      nmi_req_reg <= 1'b0;
    end else begin
      nmi_req_reg <= nmi_req_next;
    end
  end

  // Shared strobe: address strobe or windowed I/O strobe
  always_comb begin
    strobe_n_next = 1'b1;
    if (extended_mode_enable_reg && ext_access) begin
      if (!strobe_function_select_reg) begin
        strobe_n_next = 1'b0;
      end else if (msc_in_ios(ext_addr[15:0])) begin
        strobe_n_next = 1'b0;
      end
    end
  end

  // Strobe pin level, idle high
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      strobe_n_reg <= 1'b1;
    end else begin
      strobe_n_reg <= strobe_n_next;
    end
  end

  // Strobe pin enable; pin driven only in extended mode
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      strobe_oe_reg <= 1'b0;
    end else begin
      strobe_oe_reg <= extended_mode_enable_reg;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata            = rdata_reg;
  assign nmi_request          = nmi_req_reg;
  assign shared_strobe_pin_n  = strobe_n_reg;
  assign shared_strobe_pin_oe = strobe_oe_reg;
  assign extended_mode_enable = extended_mode_enable_reg;
  assign irq_ctrl_mode        = {1'b0, irq_ctrl_mode_lo_reg};
  assign onchip_ram_enable    = onchip_ram_enable_reg;
  assign reset_source_flag    = reset_source_flag_reg;
  assign mode_pin_status      = status_reg;

endmodule

//--- tb/msc_regs_monitor.sv
`timescale 1ns/1ps
module msc_regs_monitor
  import msc_pkg::*;
#(
  parameter int BUS_ADDR_W = 24
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  wdt_overflow,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  mode_select_pin_2,
  input wire logic                  mode_select_pin_1,
  input wire logic                  mode_select_pin_0,
  input wire logic                  ext_access,
  input wire logic [BUS_ADDR_W-1:0] ext_addr,
  input wire logic                  nmi_in,
  input wire logic                  nmi_request,
  input wire logic                  shared_strobe_pin_n,
  input wire logic                  extended_mode_enable,
  input wire logic [1:0]            irq_ctrl_mode,
  input wire logic                  onchip_ram_enable,
  input wire logic                  reset_source_flag
);
  wire logic [2:0] pins_now = {mode_select_pin_2, mode_select_pin_1,
                               mode_select_pin_0};
  wire logic       sc_wr = reg_wr && reg_addr == MSC_OFS_SYSTEM_CONTROL;
  logic            eg_q;
  logic            strobe_function_select_q;
  // Shadow of the edge and strobe selects as software wrote them
  always_ff @(posedge sys_clk) begin
    if (rst || wdt_overflow) begin
      eg_q   <= 1'h0;
      strobe_function_select_q <= 1'h0;
    end else if (sc_wr) begin
      eg_q   <= reg_wdata[2];
      strobe_function_select_q <= reg_wdata[6];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || wdt_overflow);
  property p_mc; $past(reg_rd && reg_addr == MSC_OFS_MODE_CONTROL) |->
    reg_rdata[6:3] == 4'h0 && reg_rdata[2:0] == $past(pins_now); endproperty
  property p_mode1; pins_now == MSC_PINS_MODE1 &&
    $past(pins_now) == MSC_PINS_MODE1 |-> extended_mode_enable; endproperty
  property p_intm; irq_ctrl_mode[1] == 1'h0; endproperty
  property p_wr; sc_wr |=> {irq_ctrl_mode[0], onchip_ram_enable} ==
    $past({reg_wdata[4], reg_wdata[0]}); endproperty
  property p_nmi; (eg_q ? $rose(nmi_in) : $fell(nmi_in)) |=>
    nmi_request ##1 !nmi_request; endproperty
  property p_src_ext; $past(rst) |-> reset_source_flag; endproperty
  property p_src_wdt; $past(wdt_overflow && !rst) |-> !reset_source_flag;
  endproperty
  property p_src_hold; !$past(rst || wdt_overflow) |->
    $stable(reset_source_flag); endproperty
  property p_as; $past(ext_access && extended_mode_enable && !strobe_function_select_q) |->
    !shared_strobe_pin_n; endproperty
  property p_ios; $past(ext_access && extended_mode_enable && strobe_function_select_q) |->
    shared_strobe_pin_n == !$past(ext_addr[15:0] >= MSC_IOS_LO &&
    ext_addr[15:0] <= MSC_IOS_HI); endproperty
  a_mc: assert property (p_mc) else $error("mode read bad");
  a_mode1: assert property (p_mode1) else $error("mode1 enable");
  a_intm: assert property (p_intm) else $error("intm high bit");
  a_wr: assert property (p_wr) else $error("sysctl write");
  a_nmi: assert property (p_nmi) else $error("nmi request");
  a_src_ext: assert property (p_src_ext) else $error("src ext");
  a_src_wdt: assert property (p_src_wdt) else $error("src wdt");
  a_src_hold: assert property (p_src_hold) else $error("src hold");
  a_as: assert property (p_as) else $error("address strobe");
  a_ios: assert property (p_ios) else $error("io strobe");
  c_nmi: cover property (nmi_request);
  c_strobe: cover property (!shared_strobe_pin_n);
  c_wdt: cover property (!reset_source_flag);
endmodule
bind msc_regs msc_regs_monitor #(.BUS_ADDR_W(BUS_ADDR_W)) u_mon (
  .sys_clk, .rst, .wdt_overflow, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .mode_select_pin_2, .mode_select_pin_1, .mode_select_pin_0,
  .ext_access, .ext_addr, .nmi_in, .nmi_request, .shared_strobe_pin_n,
  .extended_mode_enable, .irq_ctrl_mode, .onchip_ram_enable,
  .reset_source_flag);

//--- tb/msc_far_model.sv
`timescale 1ns/1ps
module msc_far_model (
  input  wire logic        sys_clk,
  output logic             ext_access,
  output logic [23:0]      ext_addr,
  output logic             nmi_in
);
  // Idle: no access, NMI line high
  initial begin
    ext_access = 1'h0;
    ext_addr   = 24'h000000;
    nmi_in     = 1'h1;
  end
  // One external-area cycle; released address shows its inverse
  task automatic access(logic [23:0] a);
    @(posedge sys_clk);
    ext_access <= 1'h1;
    ext_addr   <= a;
    @(posedge sys_clk);
    ext_access <= 1'h0;
    ext_addr   <= ~a;
  endtask
  task automatic drive_nmi(logic lvl);
    @(posedge sys_clk);
    nmi_in <= lvl;
  endtask
endmodule

//--- tb/msc_regs_tb_top.sv
`timescale 1ns/1ps
module msc_regs_tb_top;
  import msc_pkg::*;
  logic        sys_clk = 1'h0, rst = 1'h1, wdt_overflow = 1'h0;
  logic        reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0]  pins = 3'h2, mode_pin_status;
  logic [23:0] ext_addr;
  logic [1:0]  irq_ctrl_mode;
  logic        ext_access, nmi_in, nmi_request, shared_strobe_pin_n;
  logic        shared_strobe_pin_oe, extended_mode_enable;
  logic        onchip_ram_enable, reset_source_flag;
  int          err_total = 0, compares = 0;
  always #25 sys_clk = ~sys_clk;
  msc_regs i_dut (.sys_clk, .rst, .wdt_overflow, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mode_select_pin_2(pins[2]),
    .mode_select_pin_1(pins[1]), .mode_select_pin_0(pins[0]), .ext_access,
    .ext_addr, .nmi_in, .nmi_request, .shared_strobe_pin_n,
    .shared_strobe_pin_oe, .extended_mode_enable, .irq_ctrl_mode,
    .onchip_ram_enable, .reset_source_flag, .mode_pin_status);
  msc_far_model i_far (.sys_clk, .ext_access, .ext_addr, .nmi_in);
  // Counting compare of one byte
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // Read strobe, then take the data in the following cycle
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic hit_reset(bit by_wdt);
    @(posedge sys_clk);
    if (by_wdt) wdt_overflow <= 1'h1;
    else rst <= 1'h1;
    repeat (10) @(posedge sys_clk);
    rst          <= 1'h0;
    wdt_overflow <= 1'h0;
  endtask
  task automatic nmi_step(logic lvl, logic e);
    i_far.drive_nmi(lvl);
    @(posedge sys_clk);
    #1 chk("nmi", {7'h0, e}, {7'h0, nmi_request});
    @(posedge sys_clk);
    #1 chk("nmi_end", 8'h00, {7'h0, nmi_request});
  endtask
  task automatic strb(logic [23:0] a, logic e);
    i_far.access(a);
    #1 chk("strobe_n", {7'h0, e}, {7'h0, shared_strobe_pin_n});
  endtask
  task automatic t_fields();
    rdchk(MSC_OFS_MODE_CONTROL, 8'h02);
    rdchk(MSC_OFS_SYSTEM_CONTROL, 8'h09);
    wr(MSC_OFS_MODE_CONTROL, 8'hff);
    rdchk(MSC_OFS_MODE_CONTROL, 8'h82);
    wr(MSC_OFS_SYSTEM_CONTROL, 8'h9f);
    rdchk(MSC_OFS_SYSTEM_CONTROL, 8'h1f);
    chk("intm", 8'h01, {6'h0, irq_ctrl_mode});
    wr(MSC_OFS_SYSTEM_CONTROL, 8'h00);
    #1 chk("ram", 8'h00, {7'h0, onchip_ram_enable});
    rdchk(8'h05, 8'h00);
    @(posedge sys_clk);
    pins <= 3'h3;
    @(posedge sys_clk);
    #1 chk("status", 8'h02, {5'h0, mode_pin_status});
    rdchk(MSC_OFS_MODE_CONTROL, 8'h83);
  endtask
  task automatic t_nmi_strobe();
    wr(MSC_OFS_SYSTEM_CONTROL, 8'h01);
    nmi_step(1'h0, 1'h1);
    nmi_step(1'h1, 1'h0);
    wr(MSC_OFS_SYSTEM_CONTROL, 8'h05);
    nmi_step(1'h0, 1'h0);
    nmi_step(1'h1, 1'h1);
    chk("oe", 8'h01, {7'h0, shared_strobe_pin_oe});
    wr(MSC_OFS_SYSTEM_CONTROL, 8'h01);
    strb(24'h001234, 1'h0);
    wr(MSC_OFS_SYSTEM_CONTROL, 8'h41);
    strb(24'hfff000, 1'h0);
    strb(24'hfff7ff, 1'h0);
    strb(24'hfff800, 1'h1);
    strb(24'h00efff, 1'h1);
    wr(MSC_OFS_MODE_CONTROL, 8'h00);
    @(posedge sys_clk);
    #1 chk("oe_off", 8'h00, {7'h0, shared_strobe_pin_oe});
  endtask
  task automatic t_resets();
    hit_reset(1'h1);
    rdchk(MSC_OFS_SYSTEM_CONTROL, 8'h01);
    rdchk(MSC_OFS_SYSTEM_CONTROL, 8'h01);
    @(posedge sys_clk);
    pins <= 3'h1;
    rst  <= 1'h1;
    hit_reset(1'h0);
    rdchk(MSC_OFS_SYSTEM_CONTROL, 8'h09);
    rdchk(MSC_OFS_MODE_CONTROL, 8'h81);
    wr(MSC_OFS_MODE_CONTROL, 8'h00);
    rdchk(MSC_OFS_MODE_CONTROL, 8'h81);
  endtask
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end
  initial begin
    hit_reset(1'h0);
    t_fields();
    t_nmi_strobe();
    t_resets();
    give_verdict();
  end
endmodule
